/* File: host_model.sv */
// host controller model that feeds the two command ports
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic clock,
  // command ports
  output var remote_status_pkg::rx_byte_t serial_rx,
  output var remote_status_pkg::rx_byte_t bus_rx
);
  import remote_status_pkg::*;

  initial begin
    serial_rx = '0;
    bus_rx = '0;
  end

  // one byte strobe; released data shows the inverse so stale values cannot pass
  task automatic send(input logic to_bus, input logic [7:0] b, input logic e);
    @(negedge clock);
    if (to_bus) begin
      bus_rx = '{1'b1, b, e};
    end else begin
      serial_rx = '{1'b1, b, e};
    end
    @(negedge clock);
    if (to_bus) begin
      bus_rx = '{1'b0, ~b, 1'b0};
    end else begin
      serial_rx = '{1'b0, ~b, 1'b0};
    end
  endtask

  // command closed by nl (0), cr nl (1) or end-or-identify (2)
  task automatic send_cmd(input logic to_bus, input logic [7:0] b, input int term);
    send(to_bus, b, term == 2);
    if (term == 1) send(to_bus, CHAR_CR, 1'b0);
    if (term != 2) send(to_bus, CHAR_NL, 1'b0);
  endtask
endmodule
`default_nettype wire

/* File: remote_port_status_logic.sv */
// remote port arbitration, lan indicator and status byte logic
//
// Functional notes
// - lan indicator steady on with valid address, cable in, no duplicate address or lease failure, no identify
// - lan indicator blinks while identify is enabled
// - lan indicator off on any network fault while identify is disabled
// - saving a network configuration stores it then restarts the interface
// - automatic address assignment defaults to enabled after factory setup
// - first port receiving traffic after power-on becomes active
// - other port ignored until active port idle five minutes
// - service summary is OR of status bits masked by service enable
// - event summary bit set when an enabled event is recorded
// - message-available bit set while output buffer holds a response
// - command terminated by NL, CR NL or end-or-identify resets path (the logic only raises cmd_end and keeps no path state)
// - responses only follow queries, never spontaneous
`timescale 1ns/1ps
`default_nettype none
module remote_port_status_logic
  import remote_status_pkg::*;
#(
  parameter longint unsigned IDLE_COUNT = IDLE_CYCLES,
  parameter int unsigned BLINK_COUNT = BLINK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // network health and identify
  input wire remote_status_pkg::net_health_t net_health,
  input wire logic identify_en,
  output logic lan_led,
  // network configuration
  input wire logic cfg_save,
  input wire logic cfg_auto_addr,
  input wire logic factory_default,
  output logic cfg_store,
  output logic net_restart,
  output logic auto_addr_en,
  // command ports
  input wire remote_status_pkg::rx_byte_t serial_rx,
  input wire remote_status_pkg::rx_byte_t bus_rx,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic cmd_end,
  output logic [1:0] active_port,
  // output buffer and query
  input wire logic query_seen,
  input wire logic outbuf_empty,
  output logic response_allowed,
  // event and enable masks
  input wire logic [7:0] event_set,
  input wire logic esr_clear,
  input wire logic sre_write,
  input wire logic ese_write,
  input wire logic [7:0] mask_wdata,
  output logic [7:0] status_byte,
  output logic [7:0] esr_value
);
  import remote_status_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic led;
    logic [31:0] blink_cnt;
    logic blink_ph;
    logic store;
    logic restart;
    logic [7:0] restart_cnt;
    logic auto_addr;
    port_sel_t port;
    logic [39:0] idle_cnt;
    logic cvalid;
    logic [7:0] cdata;
    logic cend;
    logic prev_cr;
    logic mav;
    logic resp_ok;
    logic [7:0] esr;
    logic [7:0] sre;
    logic [7:0] ese;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic net_fault;
  logic [7:0] status_raw;
  logic mss;
  rx_byte_t chosen;
  logic serial_ok;
  logic bus_ok;
  logic term;

  assign net_fault = !net_health.addr_valid || net_health.dup_addr || net_health.lease_fail ||
                     !net_health.cable_ok;

  // ---------------------------------------------------------------
  // port gating
  // ---------------------------------------------------------------
  // after timeout the port falls back to none, so the next talker wins
  assign serial_ok = (s_q.port == PORT_SERIAL) || (s_q.port == PORT_NONE);
  assign bus_ok = (s_q.port == PORT_BUS) || ((s_q.port == PORT_NONE) && !serial_rx.valid);

  always_comb begin
    if (serial_ok && serial_rx.valid) begin
      chosen = serial_rx;
    end else if (bus_ok && bus_rx.valid) begin
      chosen = bus_rx;
    end else begin
      chosen = '0;
    end
  end

  assign term = chosen.valid && (chosen.data == CHAR_NL || chosen.eoi);

  // ---------------------------------------------------------------
  // status byte
  // ---------------------------------------------------------------
  always_comb begin
    status_raw = STATUS_RESET;
    status_raw[STATUS_MAV_BIT] = s_q.mav;
    status_raw[STATUS_ESB_BIT] = |(s_q.esr & s_q.ese);
  end
  // unlatched: summary follows the masked bits combinationally
  assign mss = |(status_raw & s_q.sre & ~(8'h01 << STATUS_MSS_BIT));

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // lan indicator
    if (s_q.blink_cnt >= BLINK_COUNT - 1) begin
      s_d.blink_cnt = '0;
      s_d.blink_ph = !s_q.blink_ph;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 32'd1;
    end
    if (identify_en) begin
      s_d.led = s_q.blink_ph;
    end else if (net_fault) begin
      s_d.led = 1'b0;
    end else begin
      s_d.led = 1'b1;
    end
    // configuration save then restart
    s_d.store = 1'b0;
    if (factory_default) begin
      s_d.auto_addr = AUTO_ADDR_RESET;
    end else if (cfg_save) begin
      s_d.auto_addr = cfg_auto_addr;
      s_d.store = 1'b1;
    end
    if (s_q.store) begin
      s_d.restart = 1'b1;
      s_d.restart_cnt = 8'(RESTART_CYCLES);
    end else if (s_q.restart_cnt > 8'd1) begin
      s_d.restart_cnt = s_q.restart_cnt - 8'd1;
    end else begin
      s_d.restart = 1'b0;
      s_d.restart_cnt = '0;
    end
    // port selection and idle timer
    if (chosen.valid) begin
      s_d.idle_cnt = '0;
      if (s_q.port == PORT_NONE) begin
        s_d.port = (serial_ok && serial_rx.valid) ? PORT_SERIAL : PORT_BUS;
      end
    end else if (s_q.port != PORT_NONE) begin
      if (64'(s_q.idle_cnt) >= IDLE_COUNT - 64'd1) begin
        s_d.port = PORT_NONE;
        s_d.idle_cnt = '0;
      end else begin
        s_d.idle_cnt = s_q.idle_cnt + 40'd1;
      end
    end
    // command stream; CR ahead of NL is swallowed
    s_d.cvalid = chosen.valid && !(chosen.data == CHAR_CR && !chosen.eoi);
    s_d.cdata = chosen.data;
    s_d.cend = term;
    if (chosen.valid) begin
      s_d.prev_cr = (chosen.data == CHAR_CR);
    end
    // responses only after a query
    if (query_seen) begin
      s_d.resp_ok = 1'b1;
    end else if (outbuf_empty && !s_q.mav) begin
      s_d.resp_ok = 1'b0;
    end
    if (!outbuf_empty && s_q.resp_ok) begin
      s_d.mav = 1'b1;
    end else if (outbuf_empty) begin
      s_d.mav = 1'b0;
    end
    // event register: set wins over clear
    s_d.esr = (esr_clear ? 8'h00 : s_q.esr) | event_set;
    if (sre_write) begin
      s_d.sre = mask_wdata;
    end
    if (ese_write) begin
      s_d.ese = mask_wdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.port <= PORT_NONE;
      s_q.auto_addr <= AUTO_ADDR_RESET;
      s_q.sre <= SRE_RESET;
      s_q.ese <= ESE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign lan_led = s_q.led;
  assign cfg_store = s_q.store;
  assign net_restart = s_q.restart;
  assign auto_addr_en = s_q.auto_addr;
  assign cmd_valid = s_q.cvalid;
  assign cmd_data = s_q.cdata;
  assign cmd_end = s_q.cend;
  assign active_port = s_q.port;
  assign response_allowed = s_q.resp_ok;
  assign esr_value = s_q.esr;
  always_comb begin
    status_byte = status_raw;
    status_byte[STATUS_MSS_BIT] = mss;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence save_seq;
    cfg_save && !factory_default;
  endsequence

  // a bare carriage return, then the newline that closes the command
  sequence cr_byte_seq;
    chosen.valid && chosen.data == CHAR_CR && !chosen.eoi;
  endsequence

  sequence nl_byte_seq;
    chosen.valid && chosen.data == CHAR_NL;
  endsequence

  chk_led_steady_on: assert property (!identify_en && !net_fault ##1 !identify_en |-> lan_led)
    else $error("lan indicator not lit in normal operation");
  chk_led_fault_off: assert property (net_fault && !identify_en |=> lan_led == 1'b0 || identify_en)
    else $error("lan indicator lit during fault");
  chk_led_blink: assert property (identify_en |=> lan_led == $past(s_q.blink_ph))
    else $error("lan indicator not following blink phase");
  chk_save_restart: assert property (save_seq |=> cfg_store ##1 net_restart)
    else $error("restart did not follow save");
  chk_factory_auto: assert property (factory_default |=> auto_addr_en)
    else $error("auto address not enabled after factory default");
  chk_port_first: assert property (active_port == PORT_NONE && serial_rx.valid |=>
    active_port == PORT_SERIAL)
    else $error("first talker not selected");
  chk_port_locked: assert property (active_port == PORT_SERIAL && !serial_rx.valid && bus_rx.valid |=>
    !cmd_valid)
    else $error("inactive port traffic passed");
  chk_bus_locked: assert property (active_port == PORT_BUS && serial_rx.valid && !bus_rx.valid |=>
    !cmd_valid)
    else $error("serial traffic passed while bus active");
  chk_idle_restart: assert property (serial_rx.valid && active_port == PORT_SERIAL |=>
    s_q.idle_cnt == 40'h0)
    else $error("idle timer not restarted");
  chk_bus_idle: assert property (bus_rx.valid && active_port == PORT_BUS |=> s_q.idle_cnt == 40'h0)
    else $error("idle timer not restarted on bus");
  chk_mss_summary: assert property (status_byte[STATUS_MSS_BIT] == |(status_byte & s_q.sre & 8'hBF))
    else $error("service summary mismatch");
  chk_esb_summary: assert property ((|(esr_value & s_q.ese)) == status_byte[STATUS_ESB_BIT])
    else $error("event summary mismatch");
  chk_mav_clear: assert property (outbuf_empty |=> !status_byte[STATUS_MAV_BIT])
    else $error("message available not cleared");
  chk_resp_query: assert property (!status_byte[STATUS_MAV_BIT] && !response_allowed |=>
    !status_byte[STATUS_MAV_BIT])
    else $error("message available without a query");
  chk_query_opens: assert property (query_seen |=> response_allowed)
    else $error("query did not open the response path");
  chk_term_end: assert property (term |=> cmd_end)
    else $error("terminator not flagged");
  chk_cr_swallow: assert property (cr_byte_seq |=> !cmd_valid && !cmd_end)
    else $error("bare carriage return passed on");
  chk_crnl_end: assert property (s_q.prev_cr ##0 nl_byte_seq |=> cmd_valid && cmd_end)
    else $error("carriage return newline not flagged");
  chk_restart_load: assert property ($rose(net_restart) |-> s_q.restart_cnt == 8'(RESTART_CYCLES))
    else $error("restart counter not loaded");
  chk_restart_hold: assert property (net_restart && s_q.restart_cnt > 8'h01 |=> net_restart)
    else $error("restart ended early");

endmodule
`default_nettype wire

/* File: remote_status_pkg.sv */
// package: constants and carriers for the remote port and status logic
`default_nettype none
package remote_status_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLOCK_HZ = 64'd10_000_000;
  localparam int unsigned IDLE_MINUTES = 5;
  localparam longint unsigned IDLE_CYCLES = 64'(IDLE_MINUTES) * 64'd60 * CLOCK_HZ;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYCLES = BLINK_MS * 10_000;
  localparam int unsigned RESTART_CYCLES = 16;

  // ---------------------------------------------------------------
  // status byte layout and reset values
  // ---------------------------------------------------------------
  localparam int unsigned STATUS_MAV_BIT = 4;
  localparam int unsigned STATUS_ESB_BIT = 5;
  localparam int unsigned STATUS_MSS_BIT = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic AUTO_ADDR_RESET = 1'b1;

  // ---------------------------------------------------------------
  // terminators
  // ---------------------------------------------------------------
  localparam logic [7:0] CHAR_NL = 8'h0A;
  localparam logic [7:0] CHAR_CR = 8'h0D;

  typedef enum logic [1:0] {
    PORT_NONE   = 2'b00,
    PORT_SERIAL = 2'b01,
    PORT_BUS    = 2'b10
  } port_sel_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       eoi;
  } rx_byte_t;

  typedef struct packed {
    logic addr_valid;
    logic cable_ok;
    logic dup_addr;
    logic lease_fail;
  } net_health_t;

endpackage
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the remote port and status logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import remote_status_pkg::*;
  logic clock = 1'b0, arst_n = 1'b0, identify_en = 1'b0, cfg_save = 1'b0, cfg_auto_addr = 1'b1;
  logic factory_default = 1'b0, query_seen = 1'b0, outbuf_empty = 1'b1, esr_clear = 1'b0;
  logic sre_write = 1'b0, ese_write = 1'b0;
  logic [7:0] event_set = 8'h00, mask_wdata = 8'h00;
  net_health_t net_health = '0;
  rx_byte_t serial_rx, bus_rx;
  logic lan_led, cfg_store, net_restart, auto_addr_en, cmd_valid, cmd_end, response_allowed;
  logic [7:0] cmd_data, status_byte, esr_value;
  logic [1:0] active_port;
  int err_count = 0, comparisons = 0, cycles = 0, toggles;
  logic prev_led = 1'b0;

  always #50 clock = ~clock;

  remote_port_status_logic #(.IDLE_COUNT(64'd50), .BLINK_COUNT(4)) remote_port_status_logic_inst (
    .clock, .arst_n, .net_health, .identify_en, .lan_led, .cfg_save, .cfg_auto_addr,
    .factory_default, .cfg_store, .net_restart, .auto_addr_en, .serial_rx, .bus_rx,
    .cmd_valid, .cmd_data, .cmd_end, .active_port, .query_seen, .outbuf_empty,
    .response_allowed, .event_set, .esr_clear, .sre_write, .ese_write, .mask_wdata,
    .status_byte, .esr_value);

  host_model host_model_inst (.clock(clock), .serial_rx(serial_rx), .bus_rx(bus_rx));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr_mask(input logic to_sre, input logic [7:0] v);
    @(negedge clock);
    mask_wdata = v;
    sre_write = to_sre;
    ese_write = ~to_sre;
    @(negedge clock);
    sre_write = 1'b0;
    ese_write = 1'b0;
    tick(2);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // hang guard, well above the few hundred cycles the tests need
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    tick(12);
    arst_n = 1'b1;
    check("auto_addr_en", 8'(auto_addr_en), 8'h01);
    check("active_port", 8'(active_port), 8'h00);
    check("status_byte", status_byte, 8'h00);
    // lan indicator: good, each fault in turn, identify blink
    net_health = 4'hC;
    tick(3);
    check("lan_led", 8'(lan_led), 8'h01);
    for (int i = 0; i < 4; i++) begin
      net_health = 4'hC ^ (4'h8 >> i);
      tick(3);
      check("lan_led", 8'(lan_led), 8'h00);
    end
    net_health = 4'hC;
    identify_en = 1'b1;
    toggles = 0;
    prev_led = lan_led;
    repeat (12) begin
      tick(1);
      if (lan_led !== prev_led) toggles++;
      prev_led = lan_led;
    end
    // four-cycle half period: phase alignment leaves two to four flips
    check("lan_blink", 8'(toggles >= 2 && toggles <= 4), 8'h01);
    identify_en = 1'b0;
    tick(12);
    check("lan_led", 8'(lan_led), 8'h01);
    $display("test lan done");
    // configuration save then restart
    cfg_auto_addr = 1'b0;
    cfg_save = 1'b1;
    tick(1);
    cfg_save = 1'b0;
    check("cfg_store", 8'(cfg_store), 8'h01);
    check("net_restart", 8'(net_restart), 8'h00);
    tick(1);
    check("cfg_store", 8'(cfg_store), 8'h00);
    check("net_restart", 8'(net_restart), 8'h01);
    tick(15);
    check("net_restart", 8'(net_restart), 8'h01);
    tick(1);
    check("net_restart", 8'(net_restart), 8'h00);
    check("auto_addr_en", 8'(auto_addr_en), 8'h00);
    factory_default = 1'b1;
    tick(1);
    factory_default = 1'b0;
    tick(2);
    check("auto_addr_en", 8'(auto_addr_en), 8'h01);
    $display("test config done");
    // port selection, terminators and idle release
    host_model_inst.send(1'b0, 8'h41, 1'b0);
    check("cmd_valid", 8'(cmd_valid), 8'h01);
    check("cmd_data", cmd_data, 8'h41);
    check("active_port", 8'(active_port), 8'h01);
    host_model_inst.send(1'b1, 8'h42, 1'b0);
    check("cmd_valid", 8'(cmd_valid), 8'h00);
    for (int t = 0; t < 3; t++) begin
      host_model_inst.send_cmd(1'b0, 8'h3F, t);
      check("cmd_end", 8'(cmd_end), 8'h01);
    end
    host_model_inst.send(1'b0, CHAR_CR, 1'b0);
    check("cmd_valid", 8'(cmd_valid), 8'h00);
    host_model_inst.send(1'b0, CHAR_NL, 1'b0);
    tick(40);
    host_model_inst.send(1'b0, 8'h43, 1'b0);
    tick(40);
    check("active_port", 8'(active_port), 8'h01);
    tick(15);
    check("active_port", 8'(active_port), 8'h00);
    host_model_inst.send(1'b1, 8'h44, 1'b0);
    check("active_port", 8'(active_port), 8'h02);
    check("cmd_data", cmd_data, 8'h44);
    host_model_inst.send(1'b0, 8'h45, 1'b0);
    check("cmd_valid", 8'(cmd_valid), 8'h00);
    $display("test ports done");
    // status byte summaries and message available
    wr_mask(1'b0, 8'h01);
    event_set = 8'h01;
    tick(1);
    event_set = 8'h00;
    tick(2);
    check("esr_value", esr_value, 8'h01);
    check("status_byte", status_byte, 8'h20);
    wr_mask(1'b1, 8'h20);
    check("status_byte", status_byte, 8'h60);
    wr_mask(1'b1, 8'h10);
    check("status_byte", status_byte, 8'h20);
    // clear and a new event in one cycle: the new event survives
    esr_clear = 1'b1;
    event_set = 8'h02;
    tick(1);
    esr_clear = 1'b0;
    event_set = 8'h00;
    outbuf_empty = 1'b0;
    check("esr_value", esr_value, 8'h02);
    tick(3);
    check("status_byte", status_byte, 8'h00);
    query_seen = 1'b1;
    tick(1);
    query_seen = 1'b0;
    check("response_allowed", 8'(response_allowed), 8'h01);
    tick(3);
    check("status_byte", status_byte, 8'h50);
    outbuf_empty = 1'b1;
    tick(3);
    check("status_byte", status_byte, 8'h00);
    check("response_allowed", 8'(response_allowed), 8'h00);
    $display("test status done");
    // reset in mid-run drops the port selection
    check("active_port", 8'(active_port), 8'h02);
    arst_n = 1'b0;
    tick(2);
    check("active_port", 8'(active_port), 8'h00);
    check("auto_addr_en", 8'(auto_addr_en), 8'h01);
    arst_n = 1'b1;
    host_model_inst.send(1'b1, 8'h46, 1'b0);
    check("active_port", 8'(active_port), 8'h02);
    $display("test reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
